// [orddec_map.svh]
`ifndef ORDDEC_MAP_SVH
`define ORDDEC_MAP_SVH

// ---------------------------------------------------------------------------
// Register offsets on the AHB-Lite slave.
// ---------------------------------------------------------------------------
`define ORDDEC_SUBREG_BASE    8'h00
`define ORDDEC_SUBREG_END     8'h1c
`define ORDDEC_CTRL_OFF       8'h20
`define ORDDEC_STATUS_OFF     8'h24
`define ORDDEC_CTRL_EN_BIT    0
`define ORDDEC_STATUS_ILL_BIT 0
`define ORDDEC_CTRL_RESET_EN  1'b1

// ---------------------------------------------------------------------------
// Field sizes.
// ---------------------------------------------------------------------------
`define ORDDEC_IMM_BITS       10
`define ORDDEC_SUBREG_COUNT   8
`define ORDDEC_SUBREG_BITS    16
`define ORDDEC_LANES          8
`define ORDDEC_ELEM_BITS      32

// ---------------------------------------------------------------------------
// Row stride codes and element counts.
// ---------------------------------------------------------------------------
`define ORDDEC_RS_0           4'h0
`define ORDDEC_RS_1           4'h1
`define ORDDEC_RS_2           4'h2
`define ORDDEC_RS_4           4'h3
`define ORDDEC_RS_8           4'h4
`define ORDDEC_RS_16          4'h5
`define ORDDEC_RS_32          4'h6
`define ORDDEC_RS_MRI         4'hf
`define ORDDEC_MAX_STRIDE     6'h20
`define ORDDEC_MAX_ROW_SHIFT  3'h3

// ---------------------------------------------------------------------------
// Element size codes.
// ---------------------------------------------------------------------------
`define ORDDEC_ES_BYTE        2'h0
`define ORDDEC_ES_WORD        2'h1

`endif

// [orddec_pkg.sv]
package orddec_pkg;

    typedef enum logic [1:0] {
        SM_NONE,
        SM_ABS,
        SM_NEG,
        SM_NEG_ABS
    } orddec_modifier_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_DATA
    } orddec_bus_t;

    typedef struct packed {
        logic           is_source;
        logic           is_immediate;
        logic           indirect_select;
        logic           sixteen_aligned_access;
        logic [1:0]     elem_size;
        logic [2:0]     execution_lane_count;
        logic [2:0]     width;
        logic [2:0]     addr_subreg;
        logic [9:0]     addr_imm;
        orddec_modifier_t source_modifier;
        logic [3:0]     row_stride;
    } orddec_op_t;

    typedef struct packed {
        logic [7:0][15:0] row_origin;
        logic [3:0]       row_count;
        logic [5:0]       stride_elems;
        logic             multi_row_indirect;
        logic             origin_valid;
        logic             illegal;
    } orddec_res_t;

endpackage : orddec_pkg

// [orddec_source_modifier.sv]
`timescale 1ns/1ps
module orddec_lane_modifier #(
    parameter int EW = 32
) (
    // Modifier and element.
    input  wire orddec_pkg::orddec_modifier_t mod,
    input  wire logic [EW-1:0]                elem_in,
    output logic [EW-1:0]                     elem_out
);
    import orddec_pkg::*;

    logic [EW-1:0] mag;

    always_comb begin
        mag = elem_in;
        if (mod == SM_ABS || mod == SM_NEG_ABS) begin
            mag = elem_in[EW-1] ? -elem_in : elem_in;
        end
        elem_out = mod[1] ? -mag : mag;
    end

endmodule : orddec_lane_modifier

// [orddec_addr.sv]
`timescale 1ns/1ps
`include "orddec_map.svh"
module orddec_addr #(
    parameter int N  = `ORDDEC_SUBREG_COUNT,
    parameter int W  = `ORDDEC_SUBREG_BITS,
    parameter int IW = $clog2(N)
) (
    // Clock and reset.
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // Software write port.
    input  wire logic                        wr_en,
    input  wire logic [IW-1:0]               wr_idx,
    input  wire logic [W-1:0]                wr_data,
    // Origin request.
    input  wire logic [IW-1:0]               base_idx,
    input  wire logic [`ORDDEC_IMM_BITS-1:0] imm,
    input  wire logic                        multi_row,
    // Contents and origins.
    output logic [N-1:0][W-1:0]              subreg,
    output logic [N-1:0][W-1:0]              origin
);
    typedef struct packed {
        logic [N-1:0][W-1:0] word;
    } orddec_addr_state_t;

    orddec_addr_state_t st_q;
    orddec_addr_state_t st_d;
    logic [W-1:0]       offset;
    logic [IW-1:0]      idx;

    assign subreg = st_q.word;

    always_comb begin
        st_d = st_q;
        if (wr_en) begin
            st_d.word[wr_idx] = wr_data;
        end
    end

    always_comb begin
        offset = {{(W-`ORDDEC_IMM_BITS){imm[`ORDDEC_IMM_BITS-1]}}, imm};
        idx    = base_idx;
        for (int i = 0; i < N; i++) begin
            idx = base_idx + IW'(i);
            if (i == 0 || multi_row) begin
                origin[i] = st_q.word[idx] + offset;
            end else begin
                origin[i] = '0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : orddec_addr

// [orddec_top.sv]
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "orddec_map.svh"
// ---------------------------------------------------------------------------
// How it works
// - Address immediate is sign-extended and added to the address word.
// - Every immediate from -512 to 511 is accepted.
// - Immediate is used only for indirect operands; direct gives no origin.
// - Modifier 00 none, 01 absolute, 10 negate, 11 negated absolute.
// - Absolute value is taken before negation, so result is never positive.
// - Modifier acts on every element lane separately.
// - Modifier and row stride never touch a destination operand.
// - Immediate sources skip modifier and row stride decoding.
// - Row stride is counted in elements, not bytes.
// - Row stride is zero or a power of two, at most 32.
// - Stride code 0xF is honoured only with indirect addressing.
// - Code 0xF takes each row origin from its own address word.
// - With code 0xF, rows used equal lane count divided by operand width.
// - Sixteen-aligned access allows only stride codes 0000 and 0011.
// - Stride codes 0..6 map to 0,1,2,4,8,16,32; 7..14 reserved.
// - Eight 16-bit address registers hold indirect byte addresses.
// ---------------------------------------------------------------------------
module orddec_top #(
    parameter int LANES = `ORDDEC_LANES,
    parameter int EW    = `ORDDEC_ELEM_BITS
) (
    // Clock and reset.
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // AHB-Lite slave.
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    // Operand from issue.
    input  wire logic                    op_valid,
    input  wire orddec_pkg::orddec_op_t  op,
    input  wire logic [LANES*EW-1:0]     elem_in,
    // Decoded operand to the execution pipe.
    output logic                         res_valid,
    output orddec_pkg::orddec_res_t      res,
    output logic [LANES*EW-1:0]          elem_out
);
    import orddec_pkg::*;

    typedef struct packed {
        orddec_bus_t          bus;
        logic                 bus_write;
        logic [7:0]           bus_addr;
        logic                 hready;
        logic                 hresp;
        logic [31:0]          hrdata;
        logic                 decode_enable;
        logic                 illegal_sticky;
        logic [15:0]          last_origin;
        logic                 res_valid;
        orddec_res_t          res;
        logic [LANES*EW-1:0]  elem;
    } orddec_state_t;

    localparam orddec_state_t ST_RESET = '{
        bus:           BUS_IDLE,
        hready:        1'b1,
        decode_enable: `ORDDEC_CTRL_RESET_EN,
        default:       '0
    };

    orddec_state_t         st_q;
    orddec_state_t         st_d;
    logic                  src_fields;
    logic                  mri;
    orddec_modifier_t      mod_sel;
    logic [LANES*EW-1:0]   mod_out;
    logic                  sub_we;
    logic [2:0]            sub_idx;
    logic [15:0]           sub_wdata;
    logic [7:0][15:0]      sub_q;
    logic [7:0][15:0]      origin;
    logic                  accept;

    // -----------------------------------------------------------------------
    // Source field gating.
    // -----------------------------------------------------------------------
    assign src_fields = op.is_source && !op.is_immediate;
    assign mri        = src_fields && op.indirect_select &&
                        op.row_stride == `ORDDEC_RS_MRI;
    assign mod_sel    = src_fields ? op.source_modifier : SM_NONE;
    assign accept     = hsel && htrans[1] && hready && st_q.hready;

    // -----------------------------------------------------------------------
    // Per-lane source modifier and address registers.
    // -----------------------------------------------------------------------
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        orddec_lane_modifier #(
            .EW (EW)
        ) u_mod (
            .mod      (mod_sel),
            .elem_in  (elem_in[g*EW +: EW]),
            .elem_out (mod_out[g*EW +: EW])
        );
    end

    orddec_addr #(
        .N (`ORDDEC_SUBREG_COUNT),
        .W (`ORDDEC_SUBREG_BITS)
    ) u_addr (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .wr_en     (sub_we),
        .wr_idx    (sub_idx),
        .wr_data   (sub_wdata),
        .base_idx  (op.addr_subreg),
        .imm       (op.addr_imm),
        .multi_row (mri),
        .subreg    (sub_q),
        .origin    (origin)
    );

    // -----------------------------------------------------------------------
    // Next state.
    // -----------------------------------------------------------------------
    always_comb begin
        logic [5:0] stride;
        logic       bad;
        logic [2:0] diff;
        logic [3:0] rows;
        stride    = '0;
        bad       = 1'b0;
        diff      = '0;
        rows      = 4'h1;
        st_d      = st_q;
        sub_we    = 1'b0;
        sub_idx   = st_q.bus_addr[4:2];
        sub_wdata = hwdata[15:0];

        case (st_q.bus)
            BUS_IDLE: begin
                if (accept) begin
                    st_d.bus       = BUS_DATA;
                    st_d.bus_write = hwrite;
                    st_d.bus_addr  = haddr[7:0];
                    st_d.hready    = 1'b0;
                end
            end
            BUS_DATA: begin
                st_d.bus    = BUS_IDLE;
                st_d.hready = 1'b1;
                st_d.hrdata = '0;
                if (st_q.bus_write) begin
                    if (st_q.bus_addr <= `ORDDEC_SUBREG_END &&
                        st_q.bus_addr[1:0] == 2'h0) begin
                        sub_we = 1'b1;
                    end else if (st_q.bus_addr == `ORDDEC_CTRL_OFF) begin
                        st_d.decode_enable = hwdata[`ORDDEC_CTRL_EN_BIT];
                    end else if (st_q.bus_addr == `ORDDEC_STATUS_OFF &&
                                 hwdata[`ORDDEC_STATUS_ILL_BIT]) begin
                        st_d.illegal_sticky = 1'b0;
                    end
                end else begin
                    if (st_q.bus_addr <= `ORDDEC_SUBREG_END &&
                        st_q.bus_addr[1:0] == 2'h0) begin
                        st_d.hrdata = {16'h0000, sub_q[sub_idx]};
                    end else if (st_q.bus_addr == `ORDDEC_CTRL_OFF) begin
                        st_d.hrdata = {31'h0, st_q.decode_enable};
                    end else if (st_q.bus_addr == `ORDDEC_STATUS_OFF) begin
                        st_d.hrdata = {st_q.last_origin, 15'h0000,
                                       st_q.illegal_sticky};
                    end
                end
            end
            default: begin
                st_d.bus    = BUS_IDLE;
                st_d.hready = 1'b1;
            end
        endcase

        if (src_fields) begin
            case (op.row_stride)
                `ORDDEC_RS_0:  stride = 6'h00;
                `ORDDEC_RS_1:  stride = 6'h01;
                `ORDDEC_RS_2:  stride = 6'h02;
                `ORDDEC_RS_4:  stride = 6'h04;
                `ORDDEC_RS_8:  stride = 6'h08;
                `ORDDEC_RS_16: begin
                    stride = 6'h10;
                    bad    = op.elem_size > `ORDDEC_ES_WORD;
                end
                `ORDDEC_RS_32: begin
                    stride = `ORDDEC_MAX_STRIDE;
                    bad    = op.elem_size != `ORDDEC_ES_BYTE;
                end
                `ORDDEC_RS_MRI: begin
                    stride = 6'h00;
                    bad    = !op.indirect_select;
                end
                default: begin
                    stride = 6'h00;
                    bad    = 1'b1;
                end
            endcase
            if (op.sixteen_aligned_access &&
                op.row_stride != `ORDDEC_RS_0 &&
                op.row_stride != `ORDDEC_RS_4) begin
                bad = 1'b1;
            end
        end

        if (mri) begin
            diff = op.execution_lane_count - op.width;
            if (op.width > op.execution_lane_count ||
                diff > `ORDDEC_MAX_ROW_SHIFT) begin
                bad  = 1'b1;
                diff = '0;
            end
            rows = 4'h1 << diff[1:0];
        end

        st_d.res_valid = 1'b0;
        st_d.res.illegal = 1'b0;
        if (op_valid && st_q.decode_enable) begin
            st_d.res_valid              = 1'b1;
            st_d.res.stride_elems       = stride;
            st_d.res.multi_row_indirect = mri;
            st_d.res.illegal            = bad;
            st_d.elem                   = mod_out;
            if (op.indirect_select) begin
                st_d.res.origin_valid = 1'b1;
                st_d.res.row_origin   = origin;
                st_d.res.row_count    = rows;
                st_d.last_origin      = origin[0];
            end else begin
                st_d.res.origin_valid = 1'b0;
                st_d.res.row_origin   = '0;
                st_d.res.row_count    = 4'h0;
            end
            if (bad) begin
                st_d.illegal_sticky = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign hreadyout = st_q.hready;
    assign hresp     = st_q.hresp;
    assign hrdata    = st_q.hrdata;
    assign res_valid = st_q.res_valid;
    assign res       = st_q.res;
    assign elem_out  = st_q.elem;

    // -----------------------------------------------------------------------
    // Assertions.
    // -----------------------------------------------------------------------
    logic        fire;
    logic [15:0] exp_origin;
    assign fire       = op_valid && st_q.decode_enable;
    assign exp_origin = sub_q[op.addr_subreg] +
                        {{6{op.addr_imm[9]}}, op.addr_imm};

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_origin_sum: assert property (
        fire && op.indirect_select |=>
            res.row_origin[0] == $past(exp_origin) && res.origin_valid)
        else $error("origin is not address word plus immediate");
    a_direct_none: assert property (
        fire && !op.indirect_select |=>
            !res.origin_valid && res.row_origin == '0)
        else $error("direct operand produced an origin");
    a_neg_lane: assert property (
        fire && src_fields && op.source_modifier == SM_NEG |=>
            elem_out[EW-1:0] == -$past(elem_in[EW-1:0]))
        else $error("negate lane mismatch");
    a_negabs_sign: assert property (
        fire && src_fields && op.source_modifier == SM_NEG_ABS |=>
            elem_out[EW-1] || elem_out[EW-1:0] == '0)
        else $error("forced negative gave a positive lane");
    a_dest_clean: assert property (
        fire && !op.is_source |=>
            res.stride_elems == 6'h00 && elem_out == $past(elem_in))
        else $error("destination was modified");
    a_imm_clean: assert property (
        fire && op.is_immediate |=>
            res.stride_elems == 6'h00 && !res.illegal &&
            elem_out == $past(elem_in))
        else $error("immediate source was decoded");
    a_stride_pow2: assert property (
        res_valid |-> $onehot0(res.stride_elems) &&
            res.stride_elems <= `ORDDEC_MAX_STRIDE)
        else $error("stride not a power of two within range");
    a_mri_direct: assert property (
        fire && src_fields && !op.indirect_select &&
        op.row_stride == `ORDDEC_RS_MRI |=> res.illegal)
        else $error("code 0xF with direct addressing not flagged");
    a_sixteen_rsv: assert property (
        fire && src_fields && op.sixteen_aligned_access &&
        op.row_stride != `ORDDEC_RS_0 && op.row_stride != `ORDDEC_RS_4
        |=> res.illegal)
        else $error("reserved code in sixteen-aligned mode not flagged");
    a_rows_count: assert property (
        res_valid && res.multi_row_indirect && !res.illegal |->
            res.row_count inside {4'h1, 4'h2, 4'h4, 4'h8})
        else $error("row count not a legal quotient");
    a_sticky_set: assert property (
        res_valid && res.illegal |-> st_q.illegal_sticky)
        else $error("illegal result did not set the sticky flag");
    a_bus_wait: assert property (
        accept |=> !hreadyout ##1 hreadyout)
        else $error("bus answer not one wait state");
    a_abs_lane: assert property (
        fire && src_fields && op.source_modifier == SM_ABS |=>
            !elem_out[EW-1] || elem_out[EW-1:0] == {1'b1, {(EW-1){1'b0}}})
        else $error("absolute lane came out negative");
    a_neg_top: assert property (
        fire && src_fields && op.source_modifier == SM_NEG |=>
            elem_out[LANES*EW-1 -: EW] == -$past(elem_in[LANES*EW-1 -: EW]))
        else $error("negate missing on the top lane");
    a_direct_rows: assert property (
        fire && !op.indirect_select |=> res.row_count == 4'h0)
        else $error("direct operand reported rows");
    a_stride_map: assert property (
        fire && src_fields && op.row_stride == `ORDDEC_RS_8 |=>
            res.stride_elems == 6'h08)
        else $error("stride code for eight elements mis-decoded");
    a_reserved_code: assert property (
        fire && src_fields && op.row_stride inside {[4'h7:4'he]} |=>
            res.illegal)
        else $error("reserved stride code not flagged");
    a_row_origins: assert property (
        fire && mri |=> res.row_origin[1] ==
            $past(sub_q[op.addr_subreg + 3'h1] +
                  {{6{op.addr_imm[9]}}, op.addr_imm}))
        else $error("second row origin not from the next address word");
    a_enable_gate: assert property (
        op_valid && !st_q.decode_enable |=> !res_valid)
        else $error("operand decoded while decoding is disabled");

    c_negabs: cover property (fire && mod_sel == SM_NEG_ABS);
    c_mri_ok: cover property (res_valid && res.multi_row_indirect &&
                              !res.illegal);
    c_sixteen: cover property (fire && op.sixteen_aligned_access);
    c_bus_wr: cover property (accept && hwrite);
    c_enable_off: cover property (op_valid && !st_q.decode_enable);

endmodule : orddec_top

// [orddec_issue_model.sv]
`timescale 1ns/1ps
module orddec_issue_model
    import orddec_pkg::*;
#(
    parameter int DW = 256
) (
    // Clock.
    input  wire logic           hclk,
    // Operand toward the decoder.
    output logic                op_valid,
    output orddec_pkg::orddec_op_t op,
    output logic [DW-1:0]       elem_in
);
    initial begin
        op_valid = 1'b0;
        op = '0;
        elem_in = '0;
    end

    // ------
    // Issues one operand, then drives scrambled idle values.
    // ------
    task automatic send(input orddec_op_t o, input logic [DW-1:0] d);
        @(posedge hclk);
        if (o.width > o.execution_lane_count) begin
            o.width = o.execution_lane_count;
        end
        op_valid <= 1'b1;
        op <= o;
        elem_in <= d;
        @(posedge hclk);
        op_valid <= 1'b0;
        op <= ~o;
        elem_in <= ~d;
    endtask : send
endmodule : orddec_issue_model

// [orddec_top_tb.sv]
`timescale 1ns/1ps
module orddec_top_tb;
    import orddec_pkg::*;
    logic         hclk;
    logic         hresetn;
    logic         hsel;
    logic [31:0]  haddr;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [2:0]   hsize;
    logic [31:0]  hwdata;
    logic         hreadyout;
    logic         hresp;
    logic [31:0]  hrdata;
    logic         op_valid;
    orddec_op_t   op;
    logic [255:0] elem_in;
    logic         res_valid;
    orddec_res_t  res;
    logic [255:0] elem_out;
    logic [31:0]  rdv;
    logic [31:0]  x;
    logic [15:0]  e;
    orddec_op_t   o;
    logic [255:0] d;
    logic [9:0]   imms [4] = '{10'h200, 10'h1ff, 10'h3ff, 10'h001};
    int           err_count;
    int           checks_done;

    orddec_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .op_valid(op_valid), .op(op),
        .elem_in(elem_in), .res_valid(res_valid), .res(res),
        .elem_out(elem_out)
    );

    orddec_issue_model im (
        .hclk(hclk), .op_valid(op_valid), .op(op), .elem_in(elem_in)
    );

    always #2 hclk = ~hclk;

    // ------
    // Helpers.
    // ------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rdy_wait;
        int n;
        n = 0;
        #1;
        while (hreadyout !== 1'b1 && n < 64) begin
            @(posedge hclk);
            #1;
            n++;
        end
        if (n == 64) err_count++;
        rdv = hrdata;
        @(posedge hclk);
    endtask : rdy_wait

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy_wait();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        rdy_wait();
    endtask : bus

    task automatic issue;
        im.send(o, d);
        #1;
        chk(res_valid, 1'b1);
    endtask : issue

    function automatic logic [15:0] wv(input int i);
        return 16'(i % 8 * 32'h220 + 32'h100);
    endfunction : wv

    function automatic logic [31:0] modf(input int m, input logic [31:0] v);
        logic [31:0] a;
        a = (m % 2 == 1 && v[31]) ? -v : v;
        return (m >= 2) ? -a : a;
    endfunction : modf

    task automatic report_and_stop;
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // ------
    // Tests.
    // ------
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        err_count = 0;
        checks_done = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h04, 32'h0);
        chk(rdv, 32'h0);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'(i * 4), {16'hdead, wv(i)});
            bus(1'b0, 8'(i * 4), 32'h0);
            chk(rdv, {16'h0, wv(i)});
        end
        bus(1'b0, 8'h40, 32'h0);
        chk(rdv, 32'h0);
        o = '0;
        d = '0;
        o.is_source = 1'b1;
        o.indirect_select = 1'b1;
        o.addr_subreg = 3'd2;
        for (int k = 0; k < 4; k++) begin
            o.addr_imm = imms[k];
            e = wv(2) + {{6{imms[k][9]}}, imms[k]};
            issue();
            chk(res.origin_valid, 1'b1);
            chk(res.row_origin[0], e);
            chk(res.illegal, 1'b0);
        end
        o.indirect_select = 1'b0;
        issue();
        chk(res.origin_valid, 1'b0);
        chk(res.row_origin[0], 16'h0);
        for (int g = 0; g < 8; g++) begin
            d[g*32+:32] = (g % 2 == 1) ? -32'(g * 9 + 1) : 32'(g * 9 + 1);
        end
        for (int m = 0; m < 4; m++) begin
            o.source_modifier = orddec_modifier_t'(m);
            issue();
            for (int g = 0; g < 8; g++) begin
                x = modf(m, d[g*32+:32]);
                chk(elem_out[g*32+:32], x);
            end
        end
        o.source_modifier = SM_NEG;
        o.row_stride = 4'h7;
        for (int k = 0; k < 2; k++) begin
            o.is_source = (k == 1);
            o.is_immediate = (k == 1);
            issue();
            chk(elem_out[63:32], d[63:32]);
            chk(res.illegal, 1'b0);
            chk(res.stride_elems, 6'h0);
        end
        o.is_immediate = 1'b0;
        o.is_source = 1'b1;
        o.source_modifier = SM_NONE;
        for (int c = 0; c < 16; c++) begin
            o.row_stride = 4'(c);
            issue();
            chk(res.illegal, c > 6);
            if (c <= 6) begin
                chk(res.stride_elems, c == 0 ? 0 : 1 << (c - 1));
            end
        end
        for (int k = 0; k < 3; k++) begin
            o.elem_size = 2'(k / 2 + 1);
            o.row_stride = (k == 1) ? 4'h6 : 4'h5;
            issue();
            chk(res.illegal, k != 0);
        end
        o.elem_size = 2'h0;
        o.sixteen_aligned_access = 1'b1;
        for (int c = 0; c < 7; c++) begin
            o.row_stride = 4'(c);
            issue();
            chk(res.illegal, c != 0 && c != 3);
        end
        o.sixteen_aligned_access = 1'b0;
        o.indirect_select = 1'b1;
        o.row_stride = 4'hf;
        o.addr_subreg = 3'd6;
        o.addr_imm = 10'h3fc;
        o.execution_lane_count = 3'd3;
        for (int w = 0; w < 4; w++) begin
            o.width = 3'(w);
            issue();
            chk(res.multi_row_indirect, 1'b1);
            chk(res.row_count, 8 >> w);
            chk(res.illegal, 1'b0);
            for (int i = 0; i < (8 >> w); i++) begin
                chk(res.row_origin[i], wv(6 + i) - 16'h4);
            end
        end
        bus(1'b0, 8'h24, 32'h0);
        chk(rdv[0], 1'b1);
        chk(rdv[31:16], wv(6) - 16'h4);
        bus(1'b1, 8'h24, 32'h1);
        bus(1'b0, 8'h24, 32'h0);
        chk(rdv[0], 1'b0);
        bus(1'b0, 8'h20, 32'h0);
        chk(rdv, 32'h1);
        chk(hresp, 1'b0);
        bus(1'b1, 8'h20, 32'h0);
        im.send(o, d);
        #1;
        chk(res_valid, 1'b0);
        bus(1'b1, 8'h20, 32'h1);
        issue();
        chk(res.multi_row_indirect, 1'b1);
        chk(res.row_origin[1], wv(7) - 16'h4);
        report_and_stop();
    end

    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule : orddec_top_tb
